/* hdl/dtr_ctrl.sv */
/*
 * dtr_ctrl: two ORed trigger engines, shared trigger bus and multiple-record
 * segment sequencer with Wishbone register file and interrupt.
 * Assumes ADC samples of both channels and the external trigger arrive on
 * clk_sys_i; the trigger bus is an asynchronous active-low open-drain line.
 */
// Behaviour
// - trigger is the OR of two engines, each with own source, level, slope.
// - same input, upper and lower limits: trigger outside the window.
// - different sources: first qualifying edge on either source triggers.
// - external trigger may be a source but its samples are never stored.
// - every card may drive the shared bus; all accept bus trigger.
// - any channel on any card can start acquisition system wide.
// - multiple-record stores one segment per trigger, back to back in memory.
// - multiple-record segments hold only post-trigger samples unless pre mode.
// - pre mode keeps exactly 20 pre-trigger samples; rest post-trigger.
// - after a segment the trigger re-arms by itself, no software action.
// - re-arm takes a fixed count of clocks; dual mode count differs.
// - an engine fires when its source crosses the level in set slope.
// - only the 8 upper bits of a level setting form the threshold.
`timescale 1ns/1ps
module dtr_ctrl #(
	parameter int DW         = 8,
	parameter int AW         = 16,
	parameter int MEM_DEPTH  = 65536,
	parameter int REARM_SGL  = dtr_pkg::REARM_SGL,
	parameter int REARM_DUAL = dtr_pkg::REARM_DUAL
) (
	input  wire logic            clk_sys_i,
	input  wire logic            rstn_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic [DW-1:0]   smp_a_i,
	input  wire logic [DW-1:0]   smp_b_i,
	input  wire logic [DW-1:0]   smp_ext_i,
	input  wire logic            trig_bus_n_i,
	output logic                 trig_bus_n_o,
	output logic                 trig_bus_oe_o,
	output logic                 mem_we_o,
	output logic      [AW-1:0]   mem_addr_o,
	output logic      [2*DW-1:0] mem_wdata_o,
	output logic                 irq_o
);
	// ------------------------------------------------------------------
	// registers and internal signals
	// ------------------------------------------------------------------
	localparam logic [AW:0] DEPTH_L = (AW+1)'(MEM_DEPTH);
	localparam logic [4:0]  RA_S    = 5'(REARM_SGL);
	localparam logic [4:0]  RA_D    = 5'(REARM_DUAL);

	logic [dtr_pkg::CTRL_W-1:0] ctrl_reg;
	logic [31:0]                eng0_reg;
	logic [31:0]                eng1_reg;
	logic [15:0]                seglen_reg;
	logic [15:0]                segmax_reg;
	logic [dtr_pkg::IRQ_W-1:0]  istat_reg;
	logic [dtr_pkg::IRQ_W-1:0]  imask_reg;
	logic [dtr_pkg::IRQ_W-1:0]  ievt;
	dtr_pkg::dtr_state_t        state_reg;
	logic [4:0]                 rearm_reg;
	logic [15:0]                fill_reg;
	logic [15:0]                ring_reg;
	logic [15:0]                cap_reg;
	logic [15:0]                phase_reg;
	logic [15:0]                segcnt_reg;
	logic [AW-1:0]              base_reg;
	logic                       en_q_reg;
	logic                       bus_s1_reg;
	logic                       bus_s2_reg;
	logic                       fire0;
	logic                       fire1;
	logic [DW-1:0]              src0;
	logic [DW-1:0]              src1;
	logic                       wr_hit;
	logic [31:0]                wmask;
	logic                       pre_en;
	logic [15:0]                seg_eff;
	logic [15:0]                post_len;
	logic                       fits_now;
	logic                       fits_next;
	logic                       ready;
	logic                       local_trig;
	logic                       trig_any;
	logic                       start;
	logic                       seg_end;
	logic                       more;
	logic                       pre_wr;
	logic [AW-1:0]              base_next;

	// ------------------------------------------------------------------
	// trigger engines and combination
	// ------------------------------------------------------------------
	function automatic logic [DW-1:0] pick(input logic [1:0] s, input logic [DW-1:0] a,
		input logic [DW-1:0] b, input logic [DW-1:0] e);
		pick = (s == dtr_pkg::SRC_A) ? a : (s == dtr_pkg::SRC_B) ? b : e;
	endfunction

	// source select per engine, external input allowed as a source
	assign src0 = pick(eng0_reg[1:0], smp_a_i, smp_b_i, smp_ext_i);
	assign src1 = pick(eng1_reg[1:0], smp_a_i, smp_b_i, smp_ext_i);

	dtr_trig_eng #(.DW(DW)) u_eng0 (
		.clk_sys_i    (clk_sys_i),
		.rstn_i       (rstn_i),
		.en_i         (eng0_reg[1:0] != dtr_pkg::SRC_OFF),
		.slope_fall_i (eng0_reg[dtr_pkg::ENG_SLOPE]),
		.level_i      (eng0_reg[dtr_pkg::ENG_LVL_LSB +: dtr_pkg::LVL_W]),
		.smp_i        (src0),
		.fire_o       (fire0)
	);
	dtr_trig_eng #(.DW(DW)) u_eng1 (
		.clk_sys_i    (clk_sys_i),
		.rstn_i       (rstn_i),
		.en_i         (eng1_reg[1:0] != dtr_pkg::SRC_OFF),
		.slope_fall_i (eng1_reg[dtr_pkg::ENG_SLOPE]),
		.level_i      (eng1_reg[dtr_pkg::ENG_LVL_LSB +: dtr_pkg::LVL_W]),
		.smp_i        (src1),
		.fire_o       (fire1)
	);

	// window and either-source triggering both fall out of the OR
	assign local_trig = fire0 | fire1;
	// bus trigger accepted from any card, including ourselves
	assign trig_any = local_trig | (ctrl_reg[dtr_pkg::CTRL_BACC] & ~bus_s2_reg);

	// trigger bus synchroniser
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bus_s1_reg <= 1'b1;
			bus_s2_reg <= 1'b1;
		end else begin
			bus_s1_reg <= trig_bus_n_i;
			bus_s2_reg <= bus_s1_reg;
		end
	end

	// open-drain bus drive: pull low for one cycle per local trigger
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trig_bus_n_o  <= 1'b0;
			trig_bus_oe_o <= 1'b0;
		end else begin
			trig_bus_n_o  <= 1'b0;
			trig_bus_oe_o <= local_trig & ctrl_reg[dtr_pkg::CTRL_BDRV];
		end
	end

	// ------------------------------------------------------------------
	// segment sequencer
	// ------------------------------------------------------------------
	assign pre_en   = ctrl_reg[dtr_pkg::CTRL_PRE];
	assign seg_eff  = (pre_en && seglen_reg <= dtr_pkg::PRE_SAMPLES) ?
		dtr_pkg::PRE_SAMPLES + 16'h0001 : (seglen_reg == 16'h0000) ? 16'h0001 : seglen_reg;
	assign post_len = pre_en ? seg_eff - dtr_pkg::PRE_SAMPLES : seg_eff;
	assign base_next = base_reg + seg_eff[AW-1:0];
	assign fits_now  = ({1'b0, base_reg} + (AW+1)'(seg_eff)) <= DEPTH_L;
	assign fits_next = ({1'b0, base_next} + (AW+1)'(seg_eff)) <= DEPTH_L;
	assign ready     = (rearm_reg == 5'h00) && (!pre_en || fill_reg == dtr_pkg::PRE_SAMPLES);
	assign start     = ctrl_reg[dtr_pkg::CTRL_EN] & ~en_q_reg;
	assign seg_end   = (state_reg == dtr_pkg::ST_CAPTURE) && (cap_reg == post_len - 16'h0001);
	assign more      = ctrl_reg[dtr_pkg::CTRL_MREC] && fits_next &&
		(segmax_reg == 16'h0000 || segcnt_reg + 16'h0001 < segmax_reg);
	assign pre_wr    = pre_en && (state_reg == dtr_pkg::ST_ARM || state_reg == dtr_pkg::ST_SEARCH);

	// state, counters and segment base
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg  <= dtr_pkg::ST_IDLE;
			rearm_reg  <= 5'h00;
			fill_reg   <= 16'h0000;
			ring_reg   <= 16'h0000;
			cap_reg    <= 16'h0000;
			phase_reg  <= 16'h0000;
			segcnt_reg <= 16'h0000;
			base_reg   <= '0;
			en_q_reg   <= 1'b0;
		end else begin
			en_q_reg <= ctrl_reg[dtr_pkg::CTRL_EN];
			if (pre_wr) begin
				ring_reg <= (ring_reg == dtr_pkg::PRE_SAMPLES - 16'h0001) ? 16'h0000
					: ring_reg + 16'h0001;
				if (fill_reg != dtr_pkg::PRE_SAMPLES)
					fill_reg <= fill_reg + 16'h0001;
			end
			if (!ctrl_reg[dtr_pkg::CTRL_EN]) begin
				state_reg <= dtr_pkg::ST_IDLE;
			end else begin
				unique case (state_reg)
					dtr_pkg::ST_IDLE: begin
						if (start) begin
							base_reg   <= '0;
							segcnt_reg <= 16'h0000;
							fill_reg   <= 16'h0000;
							ring_reg   <= 16'h0000;
							rearm_reg  <= ctrl_reg[dtr_pkg::CTRL_DUAL] ? RA_D : RA_S;
							state_reg  <= dtr_pkg::ST_ARM;
						end
					end
					dtr_pkg::ST_ARM: begin
						// triggers seen here are dropped
						if (rearm_reg == 5'h01 || rearm_reg == 5'h00) begin
							rearm_reg <= 5'h00;
							state_reg <= dtr_pkg::ST_SEARCH;
						end else begin
							rearm_reg <= rearm_reg - 5'h01;
						end
					end
					dtr_pkg::ST_SEARCH: begin
						if (trig_any && ready) begin
							cap_reg   <= 16'h0000;
							phase_reg <= ring_reg;
							state_reg <= dtr_pkg::ST_CAPTURE;
						end
					end
					dtr_pkg::ST_CAPTURE: begin
						// further triggers ignored until the segment ends
						cap_reg <= cap_reg + 16'h0001;
						if (seg_end) begin
							base_reg   <= base_next;
							segcnt_reg <= segcnt_reg + 16'h0001;
							fill_reg   <= 16'h0000;
							ring_reg   <= 16'h0000;
							rearm_reg  <= ctrl_reg[dtr_pkg::CTRL_DUAL] ? RA_D : RA_S;
							state_reg  <= more ? dtr_pkg::ST_ARM : dtr_pkg::ST_DONE;
						end
					end
					dtr_pkg::ST_DONE: begin
						state_reg <= dtr_pkg::ST_DONE;
					end
				endcase
			end
		end
	end

	// memory write port: channel samples only, never the external input
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mem_we_o    <= 1'b0;
			mem_addr_o  <= '0;
			mem_wdata_o <= '0;
		end else begin
			mem_we_o    <= ctrl_reg[dtr_pkg::CTRL_EN] && fits_now &&
				(pre_wr || state_reg == dtr_pkg::ST_CAPTURE);
			mem_addr_o  <= (state_reg == dtr_pkg::ST_CAPTURE) ?
				base_reg + (pre_en ? dtr_pkg::PRE_SAMPLES[AW-1:0] : '0) + cap_reg[AW-1:0]
				: base_reg + ring_reg[AW-1:0];
			mem_wdata_o <= {smp_b_i, smp_a_i};
		end
	end

	// ------------------------------------------------------------------
	// Wishbone slave and interrupt
	// ------------------------------------------------------------------
	assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
	assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign ievt   = {state_reg == dtr_pkg::ST_CAPTURE && seg_end && !more,
		seg_end, state_reg == dtr_pkg::ST_SEARCH && trig_any && ready};

	// writable registers with byte lanes
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_reg   <= '0;
			eng0_reg   <= dtr_pkg::ENG_RST;
			eng1_reg   <= dtr_pkg::ENG_RST;
			seglen_reg <= dtr_pkg::SEGLEN_RST;
			segmax_reg <= 16'h0000;
			imask_reg  <= '0;
		end else if (wr_hit) begin
			unique case (wb_adr_i)
				dtr_pkg::OFS_CTRL:
					ctrl_reg <= (ctrl_reg & ~wmask[dtr_pkg::CTRL_W-1:0]) |
						(wb_dat_i[dtr_pkg::CTRL_W-1:0] & wmask[dtr_pkg::CTRL_W-1:0]);
				dtr_pkg::OFS_ENG0:   eng0_reg <= (eng0_reg & ~wmask) | (wb_dat_i & wmask);
				dtr_pkg::OFS_ENG1:   eng1_reg <= (eng1_reg & ~wmask) | (wb_dat_i & wmask);
				dtr_pkg::OFS_SEGLEN:
					seglen_reg <= (seglen_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				dtr_pkg::OFS_SEGMAX:
					segmax_reg <= (segmax_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
				dtr_pkg::OFS_IMASK:
					imask_reg <= (imask_reg & ~wmask[dtr_pkg::IRQ_W-1:0]) |
						(wb_dat_i[dtr_pkg::IRQ_W-1:0] & wmask[dtr_pkg::IRQ_W-1:0]);
				default: ;
			endcase
		end
	end

	// sticky status, write one to clear, a new event wins over the clear
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			istat_reg <= '0;
			irq_o     <= 1'b0;
		end else begin
			if (wr_hit && wb_adr_i == dtr_pkg::OFS_ISTAT && wb_sel_i[0])
				istat_reg <= (istat_reg & ~wb_dat_i[dtr_pkg::IRQ_W-1:0]) | ievt;
			else
				istat_reg <= istat_reg | ievt;
			irq_o <= |(istat_reg & imask_reg);
		end
	end

	// single-wait ack and registered read data; unmapped reads zero
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			unique case (wb_adr_i)
				dtr_pkg::OFS_CTRL:   wb_dat_o <= 32'(ctrl_reg);
				dtr_pkg::OFS_ENG0:   wb_dat_o <= eng0_reg;
				dtr_pkg::OFS_ENG1:   wb_dat_o <= eng1_reg;
				dtr_pkg::OFS_SEGLEN: wb_dat_o <= {16'h0000, seglen_reg};
				dtr_pkg::OFS_STATUS: wb_dat_o <= {13'h0000, state_reg, segcnt_reg};
				dtr_pkg::OFS_ISTAT:  wb_dat_o <= 32'(istat_reg);
				dtr_pkg::OFS_IMASK:  wb_dat_o <= 32'(imask_reg);
				dtr_pkg::OFS_SEGMAX: wb_dat_o <= {16'h0000, segmax_reg};
				dtr_pkg::OFS_PHASE:  wb_dat_o <= {16'h0000, phase_reg};
				default:             wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	a_or_engine0: assert property (state_reg == dtr_pkg::ST_SEARCH && ready && fire0 &&
		ctrl_reg[dtr_pkg::CTRL_EN] |=> state_reg == dtr_pkg::ST_CAPTURE)
		else $error("engine 0 fire did not start capture");
	a_window_other: assert property (state_reg == dtr_pkg::ST_SEARCH && ready && fire1 &&
		!fire0 && ctrl_reg[dtr_pkg::CTRL_EN] |=> state_reg == dtr_pkg::ST_CAPTURE)
		else $error("engine 1 alone did not trigger");
	a_ext_unstored: assert property (mem_we_o |-> mem_wdata_o == $past({smp_b_i, smp_a_i}))
		else $error("stored data not channel samples");
	a_bus_drive: assert property (local_trig && ctrl_reg[dtr_pkg::CTRL_BDRV]
		|=> trig_bus_oe_o && !trig_bus_n_o)
		else $error("trigger not driven on bus");
	a_bus_accept: assert property (state_reg == dtr_pkg::ST_SEARCH && ready && !bus_s2_reg &&
		ctrl_reg[dtr_pkg::CTRL_BACC] && ctrl_reg[dtr_pkg::CTRL_EN]
		|=> state_reg == dtr_pkg::ST_CAPTURE)
		else $error("bus trigger not accepted");
	a_seg_contig: assert property (seg_end && ctrl_reg[dtr_pkg::CTRL_EN]
		|=> base_reg == $past(base_reg) + $past(seg_eff[AW-1:0]))
		else $error("next segment not adjacent");
	a_post_only: assert property (mem_we_o && !$past(pre_en)
		|-> $past(state_reg) == dtr_pkg::ST_CAPTURE)
		else $error("pre-trigger write in post-only mode");
	a_pre_twenty: assert property ($rose(state_reg == dtr_pkg::ST_CAPTURE) && $past(pre_en)
		|-> $past(fill_reg) == dtr_pkg::PRE_SAMPLES)
		else $error("capture started without full pre window");
	a_auto_rearm: assert property (seg_end && more && ctrl_reg[dtr_pkg::CTRL_EN]
		|=> state_reg == dtr_pkg::ST_ARM)
		else $error("no automatic re-arm");
	a_rearm_time: assert property ($rose(state_reg == dtr_pkg::ST_ARM)
		&& !ctrl_reg[dtr_pkg::CTRL_DUAL] && ctrl_reg[dtr_pkg::CTRL_EN] && !wr_hit
		|-> ##REARM_SGL (state_reg == dtr_pkg::ST_SEARCH || !ctrl_reg[dtr_pkg::CTRL_EN]))
		else $error("re-arm count wrong");
	a_rearm_dual: assert property ($rose(state_reg == dtr_pkg::ST_ARM)
		&& ctrl_reg[dtr_pkg::CTRL_DUAL] && ctrl_reg[dtr_pkg::CTRL_EN] && !wr_hit
		|-> ##REARM_DUAL (state_reg == dtr_pkg::ST_SEARCH || !ctrl_reg[dtr_pkg::CTRL_EN]))
		else $error("dual re-arm count wrong");
	a_ignore_busy: assert property (state_reg == dtr_pkg::ST_CAPTURE && !seg_end &&
		ctrl_reg[dtr_pkg::CTRL_EN] |=> state_reg == dtr_pkg::ST_CAPTURE &&
		cap_reg == $past(cap_reg) + 16'h0001)
		else $error("capture disturbed");

	c_window_trig: cover property (state_reg == dtr_pkg::ST_SEARCH && ready && fire0 && fire1 == 1'b0);
	c_two_segs:    cover property (seg_end ##[1:200] seg_end);
	c_pre_capture: cover property (pre_en && $rose(state_reg == dtr_pkg::ST_CAPTURE));
	c_bus_start:   cover property (!bus_s2_reg && state_reg == dtr_pkg::ST_SEARCH && ready);
endmodule

/* hdl/dtr_pkg.sv */
/*
 * dtr_pkg: register map, field positions, reset values and state encoding
 * of the dual trigger / multiple-record controller.
 * Assumes a 32-bit classic Wishbone slave with byte addresses.
 */
package dtr_pkg;
	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_ENG0   = 8'h04;
	localparam logic [7:0] OFS_ENG1   = 8'h08;
	localparam logic [7:0] OFS_SEGLEN = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ISTAT  = 8'h14;
	localparam logic [7:0] OFS_IMASK  = 8'h18;
	localparam logic [7:0] OFS_SEGMAX = 8'h1C;
	localparam logic [7:0] OFS_PHASE  = 8'h20;

	// ------------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------------
	localparam int CTRL_EN   = 0;
	localparam int CTRL_MREC = 1;
	localparam int CTRL_PRE  = 2;
	localparam int CTRL_DUAL = 3;
	localparam int CTRL_BDRV = 4;
	localparam int CTRL_BACC = 5;
	localparam int CTRL_W    = 6;

	// engine fields: source, slope, 12-bit level
	localparam int ENG_SRC_LSB = 0;
	localparam int ENG_SLOPE   = 2;
	localparam int ENG_LVL_LSB = 16;
	localparam int LVL_W       = 12;
	localparam int LVL_USED    = 8;
	localparam logic [1:0] SRC_A    = 2'h0;
	localparam logic [1:0] SRC_B    = 2'h1;
	localparam logic [1:0] SRC_EXT  = 2'h2;
	localparam logic [1:0] SRC_OFF  = 2'h3;

	// interrupt bits
	localparam int IRQ_TRIG = 0;
	localparam int IRQ_SEG  = 1;
	localparam int IRQ_DONE = 2;
	localparam int IRQ_W    = 3;

	// reset values
	localparam logic [31:0] ENG_RST    = 32'h0000_0003;
	localparam logic [15:0] SEGLEN_RST = 16'h0040;

	// segment timing
	localparam logic [15:0] PRE_SAMPLES = 16'h0014;
	localparam int          REARM_SGL   = 9;
	localparam int          REARM_DUAL  = 18;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARM,
		ST_SEARCH,
		ST_CAPTURE,
		ST_DONE
	} dtr_state_t;
endpackage

/* hdl/dtr_trig_eng.sv */
/*
 * dtr_trig_eng: one level/slope trigger engine on a sample stream.
 * Assumes samples arrive one per clock in the clock domain of clk_sys_i.
 */
`timescale 1ns/1ps
module dtr_trig_eng #(
	parameter int DW = 8
) (
	input  wire logic                     clk_sys_i,
	input  wire logic                     rstn_i,
	input  wire logic                     en_i,
	input  wire logic                     slope_fall_i,
	input  wire logic [dtr_pkg::LVL_W-1:0] level_i,
	input  wire logic [DW-1:0]            smp_i,
	output logic                          fire_o
);
	logic above;
	logic above_reg;

	// only the upper bits of the level reach the threshold
	assign above = smp_i[DW-1 -: dtr_pkg::LVL_USED] >
		level_i[dtr_pkg::LVL_W-1 -: dtr_pkg::LVL_USED];

	// crossing detector, one pulse per qualifying edge
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			above_reg <= 1'b0;
			fire_o    <= 1'b0;
		end else begin
			above_reg <= above;
			fire_o    <= en_i & (slope_fall_i ? (above_reg & ~above)
				: (~above_reg & above));
		end
	end

	a_rise_fire: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		en_i && !slope_fall_i && !above_reg && above |=> fire_o)
		else $error("rising crossing gave no fire");
	a_fire_cause: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
		fire_o |-> $past(en_i) && ($past(above) != $past(above_reg)))
		else $error("fire without crossing");
endmodule

/* verif/dtr_far_side.sv */
/*
 * dtr_far_side: adc front end of both channels and the external input,
 * and a second card sharing the open-drain trigger bus.
 * Assumes the bench sets the raw levels; the bus has a pull-up.
 */
`timescale 1ns/1ps
module dtr_far_side (
	input  wire logic       clk_sys_i,
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic [7:0] e_i,
	input  wire logic       pull_i,
	input  wire logic       dut_n_i,
	input  wire logic       dut_oe_i,
	output logic      [7:0] smp_a_o = 8'h00,
	output logic      [7:0] smp_b_o = 8'h00,
	output logic      [7:0] smp_ext_o = 8'h00,
	output logic            bus_n_o
);
	// adc pipeline: one register stage per sample
	always @(posedge clk_sys_i) begin
		smp_a_o   <= a_i;
		smp_b_o   <= b_i;
		smp_ext_o <= e_i;
	end
	// wired-and bus: low when either card pulls, else pulled up
	assign bus_n_o = !((dut_oe_i && !dut_n_i) || pull_i);
endmodule

/* verif/testbench.sv */
/*
 * testbench: trigger table, bus trigger, interrupt, multiple record and
 * pre-trigger runs of dtr_ctrl against a model of expected addresses.
 * Assumes dtr_far_side supplies samples and the shared bus wire.
 */
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic        clk_sys_i = 0, rstn_i = 0, cyc = 0, we = 0, pull = 0, tog = 0, mon = 0;
	logic [7:0]  adr = 0, a = 0, b = 0, e = 0, sa, sb, se, ha = 0, hb = 0;
	logic [31:0] wdat = 0, rdat, rd;
	logic        ack, bus_n, dn, oe, mwe, irq;
	logic [15:0] maddr, mdat;
	int          errors = 0, checks = 0, cnt = 0, exp_addr, nhi, nov, noe, last_we;
	int          gaps[$];
	localparam logic [31:0] E0 [8] = '{32'h0C000000, 32'h0C000000, 32'h0C000000,
		32'h08000000, 32'h08000000, 32'h080F0000, 32'h08100000, 32'h08000004};
	localparam logic [31:0] E1 [8] = '{32'h04000004, 32'h04000004, 32'h04000004,
		32'h08000001, 32'h08000002, 32'h3, 32'h3, 32'h3};
	localparam logic [23:0] S0 [8] = '{24'h801010, 24'h801010, 24'h801010,
		24'h101010, 24'h101010, 24'h801010, 24'h801010, 24'h101010};
	localparam logic [23:0] S1 [8] = '{24'hD01010, 24'h301010, 24'h901010,
		24'h109010, 24'h101090, 24'h811010, 24'h811010, 24'h901010};
	localparam logic X [8] = '{1, 1, 0, 1, 1, 1, 0, 0};

	always #4 clk_sys_i = ~clk_sys_i;

	dtr_ctrl i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .smp_a_i(sa), .smp_b_i(sb), .smp_ext_i(se), .trig_bus_n_i(bus_n),
		.trig_bus_n_o(dn), .trig_bus_oe_o(oe), .mem_we_o(mwe), .mem_addr_o(maddr),
		.mem_wdata_o(mdat), .irq_o(irq));
	dtr_far_side i_far (.clk_sys_i(clk_sys_i), .a_i(a), .b_i(b), .e_i(e), .pull_i(pull),
		.dut_n_i(dn), .dut_oe_i(oe), .smp_a_o(sa), .smp_b_o(sb), .smp_ext_o(se),
		.bus_n_o(bus_n));

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic final_report;
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			errors++;
			$display("wrong value %s exp %h got %h", n, x, g);
		end
	endtask
	// classic single cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1;
		we <= w;
		adr <= ad;
		wdat <= d;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) errors++;
		rd = rdat;
		cyc <= 0;
		we <= 0;
		@(posedge clk_sys_i);
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		do begin
			wb(0, dtr_pkg::OFS_ISTAT, 0);
			n++;
		end while (rd[2] !== 1'b1 && n < 300);
		if (n >= 300) errors++;
	endtask

	// sample stimulus: a toggles for repeated crossings, b random
	always @(posedge clk_sys_i) begin
		if (tog) begin
			a <= ~a;
			b <= 8'($urandom_range(0, 112));
		end
	end
	// memory write monitor, bus drive counter and timeout
	always @(posedge clk_sys_i) begin
		if (mwe === 1'b1) begin
			if (maddr >= 20) nhi++;
			if (maddr >= 24) nov++;
			if (mon) begin
				chk("mem addr", exp_addr, maddr);
				chk("mem data", {hb, ha}, mdat);
				if (exp_addr > 0 && cnt - last_we > 1) gaps.push_back(cnt - last_we);
				exp_addr++;
				last_we = cnt;
			end
		end
		if (oe === 1'b1) begin
			noe++;
			chk("bus level", 0, dn);
		end
		ha <= sa;
		hb <= sb;
		cnt++;
		if (cnt > 20000) begin
			errors++;
			final_report();
		end
	end

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		void'($urandom(32'h1E60B2BF));
		repeat (5) @(posedge clk_sys_i);
		rstn_i <= 1;
		@(posedge clk_sys_i);
		wb(0, dtr_pkg::OFS_ENG0, 0);
		chk("eng0 rst", dtr_pkg::ENG_RST, rd);
		wb(0, dtr_pkg::OFS_SEGLEN, 0);
		chk("seglen rst", {16'h0000, dtr_pkg::SEGLEN_RST}, rd);
		wb(1, 8'h30, 32'hFFFFFFFF);
		wb(0, 8'h30, 0);
		chk("unmapped", 0, rd);
		for (int i = 0; i < 8; i++) begin
			{a, b, e} <= S0[i];
			wb(1, dtr_pkg::OFS_ENG0, E0[i]);
			wb(1, dtr_pkg::OFS_ENG1, E1[i]);
			wb(1, dtr_pkg::OFS_CTRL, 32'h1);
			repeat (25) @(posedge clk_sys_i);
			wb(1, dtr_pkg::OFS_ISTAT, 32'h7);
			{a, b, e} <= S1[i];
			repeat (10) @(posedge clk_sys_i);
			wb(0, dtr_pkg::OFS_ISTAT, 0);
			chk("trigger", X[i], rd[0]);
			wb(1, dtr_pkg::OFS_CTRL, 0);
		end
		// other card starts acquisition over the bus
		wb(1, dtr_pkg::OFS_ENG0, 32'h3);
		wb(1, dtr_pkg::OFS_ENG1, 32'h3);
		wb(1, dtr_pkg::OFS_CTRL, 32'h21);
		repeat (25) @(posedge clk_sys_i);
		wb(1, dtr_pkg::OFS_ISTAT, 32'h7);
		pull <= 1;
		repeat (3) @(posedge clk_sys_i);
		pull <= 0;
		repeat (10) @(posedge clk_sys_i);
		wb(0, dtr_pkg::OFS_ISTAT, 0);
		chk("bus accept", 1, rd[0]);
		wb(1, dtr_pkg::OFS_CTRL, 0);
		// local trigger drives the bus once
		a <= 8'h10;
		wb(1, dtr_pkg::OFS_ENG0, 32'h08000000);
		wb(1, dtr_pkg::OFS_CTRL, 32'h11);
		repeat (25) @(posedge clk_sys_i);
		noe = 0;
		a <= 8'h90;
		repeat (10) @(posedge clk_sys_i);
		chk("bus drive", 1, noe);
		wb(1, dtr_pkg::OFS_CTRL, 0);
		// interrupt masked, unmasked, cleared
		wb(1, dtr_pkg::OFS_IMASK, 0);
		repeat (3) @(posedge clk_sys_i);
		chk("irq masked", 0, irq);
		wb(1, dtr_pkg::OFS_IMASK, 1);
		repeat (3) @(posedge clk_sys_i);
		chk("irq set", 1, irq);
		wb(1, dtr_pkg::OFS_ISTAT, 32'h7);
		repeat (3) @(posedge clk_sys_i);
		chk("irq clear", 0, irq);
		// multiple record, single and dual channel re-arm
		a <= 0;
		tog <= 1;
		wb(1, dtr_pkg::OFS_SEGLEN, 8);
		wb(1, dtr_pkg::OFS_SEGMAX, 3);
		for (int d = 0; d < 2; d++) begin
			wb(1, dtr_pkg::OFS_ISTAT, 32'h7);
			exp_addr = 0;
			gaps.delete();
			mon <= 1;
			wb(1, dtr_pkg::OFS_CTRL, 32'h3 | (d << 3));
			wait_done();
			chk("writes", 24, exp_addr);
			wb(0, dtr_pkg::OFS_STATUS, 0);
			chk("status", 32'h0004_0003, rd);
			chk("segments", 2, gaps.size());
			foreach (gaps[k]) begin
				chk("rearm", 1, gaps[k] > (d ? 18 : 9) && gaps[k] <= (d ? 25 : 16));
			end
			mon <= 0;
			wb(1, dtr_pkg::OFS_CTRL, 0);
		end
		// pre-trigger segment: 20 ring words then 4 post
		wb(1, dtr_pkg::OFS_ISTAT, 32'h7);
		wb(1, dtr_pkg::OFS_SEGLEN, 24);
		wb(1, dtr_pkg::OFS_SEGMAX, 1);
		nhi = 0;
		nov = 0;
		wb(1, dtr_pkg::OFS_CTRL, 32'h7);
		wait_done();
		chk("post writes", 4, nhi);
		chk("overrun", 0, nov);
		final_report();
	end
endmodule
